// File: isx_pkg.sv
// ----------------------------------------------------------------------------
// shared constants for the increment-and-skip execution block
// ----------------------------------------------------------------------------
package isx_pkg;

  // --------------------------------------------------------------------------
  // widths
  // --------------------------------------------------------------------------
  localparam int INSTR_W    = 16;
  localparam int DATA_W     = 8;
  localparam int FIELD_W    = 8;
  localparam int BANK_W     = 4;
  localparam int ADDR_W     = 12;
  localparam int PHASE_W    = 2;

  // --------------------------------------------------------------------------
  // opcode layout: top six bits select the operation, then d, a, f
  // --------------------------------------------------------------------------
  localparam int OPC_MSB    = 15;
  localparam int OPC_LSB    = 10;
  localparam int DEST_BIT   = 9;
  localparam int ACCESS_BIT = 8;
  localparam int FIELD_MSB  = 7;
  localparam int FIELD_LSB  = 0;

  // increment_skip_if_zero    0011 11da ffff ffff
  localparam logic [5:0] OPC_INC_SKIP_ZERO    = 6'h0f;
  // increment_skip_if_nonzero 0100 10da ffff ffff
  localparam logic [5:0] OPC_INC_SKIP_NONZERO = 6'h12;

  // --------------------------------------------------------------------------
  // addressing
  // --------------------------------------------------------------------------
  localparam logic [7:0] ACCESS_LOW_LAST = 8'h5f;  // f <= 95 is the low access half
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK  = 4'hf;   // upper access half maps to the top bank
  localparam logic [7:0] INCREMENT       = 8'h01;
  localparam logic [7:0] ZERO_RESULT     = 8'h00;

  // --------------------------------------------------------------------------
  // phases of one instruction cycle, one core clock each
  // --------------------------------------------------------------------------
  localparam logic [1:0] PH_DECODE  = 2'h0;
  localparam logic [1:0] PH_READ    = 2'h1;
  localparam logic [1:0] PH_PROCESS = 2'h2;
  localparam logic [1:0] PH_WRITE   = 2'h3;

  typedef enum logic [1:0] {
    ISX_IDLE,
    ISX_EXEC,
    ISX_SKIP_FIRST,
    ISX_SKIP_SECOND
  } isx_state_e;

endpackage

// File: isx_phase_gen.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// four-phase divider: one core clock per phase, one enable pulse per cycle
// ----------------------------------------------------------------------------
module isx_phase_gen (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  output logic [isx_pkg::PHASE_W-1:0]     phase,
  output logic                            cycleStart
);

  logic [isx_pkg::PHASE_W-1:0] phase_r;
  logic [isx_pkg::PHASE_W-1:0] phase_nxt;
  logic                        start_r;
  logic                        start_nxt;

  // wraps from write back to decode, so cycles follow back to back
  assign phase_nxt = phase_r + 2'h1;
  assign start_nxt = (phase_nxt == isx_pkg::PH_DECODE);

  // counter and decode-phase pulse
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= isx_pkg::PH_DECODE;
      start_r <= 1'b1;
    end else begin
      phase_r <= phase_nxt;
      start_r <= start_nxt;
    end
  end

  assign phase      = phase_r;
  assign cycleStart = start_r;

endmodule

// File: isx_exec.sv
`timescale 1ns/100ps
// Functional notes
// RQ1: read the addressed register, add one, use the sum as result.
// RQ2: skip-if-zero opcode skips the next instruction when the sum is zero.
// RQ3: destination bit one writes the sum back to the source register.
// RQ4: destination bit zero writes the working register only.
// RQ5: a taken skip flushes the fetched instruction and runs a no-op cycle.
// RQ6: one word, one cycle; a taken skip costs a second cycle.
// RQ7: skipping a two-word instruction costs three cycles in total.
// RQ8: access bit zero resolves the field inside the access bank.
// RQ9: access bit one takes the bank from the bank select register.
// RQ10: extended set, access bit zero, field at most 95 uses indexed offset.
// RQ11: decode the single-word opcode with d, a and 8-bit field.
// RQ12: skip-if-nonzero opcode skips when the sum is not zero.
// RQ13: four phases per cycle: decode, read, process, write; skip cycles idle.
module isx_exec #(
  parameter int ADDR_W = isx_pkg::ADDR_W,
  parameter int BANK_W = isx_pkg::BANK_W
) (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire logic [isx_pkg::INSTR_W-1:0]   instrWord,
  input  wire logic                          instrValid,
  input  wire logic                          nextTwoWord,
  input  wire logic                          extEnable,
  input  wire logic [BANK_W-1:0]             bankSelectReg,
  input  wire logic [ADDR_W-1:0]             indexBase,
  input  wire logic [isx_pkg::DATA_W-1:0]    memRdData,
  output logic [ADDR_W-1:0]                  memAddr,
  output logic                               memRdEn,
  output logic                               memWrEn,
  output logic [isx_pkg::DATA_W-1:0]         memWrData,
  output logic                               wregWrEn,
  output logic [isx_pkg::DATA_W-1:0]         wregData,
  output logic                               flushFetch,
  output logic                               skipActive,
  output logic                               busy
);

  // --------------------------------------------------------------------------
  // parameter checks
  // --------------------------------------------------------------------------
  // the address is the bank number on top of the 8-bit field, nothing else
  if (ADDR_W != BANK_W + isx_pkg::FIELD_W) begin : g_bad_width
    $error("address width must equal bank width plus eight");
  end

  // --------------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------------
  // effective data address of a field; used at decode for every operand
  function automatic logic [ADDR_W-1:0] resolveAddr(
    input logic                         accessBit,
    input logic [isx_pkg::FIELD_W-1:0]  field,
    input logic                         ext,
    input logic [BANK_W-1:0]            bank,
    input logic [ADDR_W-1:0]            base
  );
    logic lowHalf;
    lowHalf = (field <= isx_pkg::ACCESS_LOW_LAST);
    if (accessBit) begin
      resolveAddr = {bank, field};                                   // RQ9
    end else if (ext && lowHalf) begin
      resolveAddr = base + {{(ADDR_W-isx_pkg::FIELD_W){1'b0}}, field}; // RQ10
    end else if (lowHalf) begin
      resolveAddr = {BANK_W'(isx_pkg::ACCESS_LOW_BANK), field};      // RQ8
    end else begin
      resolveAddr = {BANK_W'(isx_pkg::ACCESS_HI_BANK), field};       // RQ8
    end
  endfunction

  // --------------------------------------------------------------------------
  // phase divider
  // --------------------------------------------------------------------------
  logic [isx_pkg::PHASE_W-1:0] phase;
  logic                        cycleStart;

  isx_phase_gen u_phase (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .phase      (phase),
    .cycleStart (cycleStart)
  );

  // --------------------------------------------------------------------------
  // state and operand registers
  // --------------------------------------------------------------------------
  isx_pkg::isx_state_e          state_r;
  isx_pkg::isx_state_e          state_nxt;
  logic                         destBit_r;
  logic                         skipOnZero_r;
  logic                         twoWord_r;
  logic [ADDR_W-1:0]            memAddr_r;
  logic                         memRdEn_r;
  logic                         memWrEn_r;
  logic [isx_pkg::DATA_W-1:0]   memWrData_r;
  logic                         wregWrEn_r;
  logic [isx_pkg::DATA_W-1:0]   wregData_r;
  logic                         flush_r;
  logic                         skipActive_r;
  logic                         busy_r;

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  wire [5:0] opcField  = instrWord[isx_pkg::OPC_MSB:isx_pkg::OPC_LSB];
  wire       isZeroOp  = (opcField == isx_pkg::OPC_INC_SKIP_ZERO);     // RQ11
  wire       isNzOp    = (opcField == isx_pkg::OPC_INC_SKIP_NONZERO);  // RQ11
  wire       inDecode  = cycleStart;  // divider pulse marks phase 0
  wire       inProcess = (phase == isx_pkg::PH_PROCESS);
  wire       inWrite   = (phase == isx_pkg::PH_WRITE);
  wire       freeCycle = (state_r == isx_pkg::ISX_IDLE) || (state_r == isx_pkg::ISX_EXEC);
  wire       accept    = inDecode && freeCycle && instrValid && (isZeroOp || isNzOp);
  wire [ADDR_W-1:0] decodedAddr = resolveAddr(instrWord[isx_pkg::ACCESS_BIT],
                                              instrWord[isx_pkg::FIELD_MSB:isx_pkg::FIELD_LSB],
                                              extEnable, bankSelectReg, indexBase);

  // --------------------------------------------------------------------------
  // process: sum and skip decision
  // --------------------------------------------------------------------------
  wire [isx_pkg::DATA_W-1:0] incResult = memRdData + isx_pkg::INCREMENT;  // RQ1
  wire       resultZero = (incResult == isx_pkg::ZERO_RESULT);
  // skip-if-zero on a zero sum, skip-if-nonzero on any other sum
  wire       skipTake   = skipOnZero_r ? resultZero : !resultZero;       // RQ2 RQ12
  wire       executing  = (state_r == isx_pkg::ISX_EXEC);

  // --------------------------------------------------------------------------
  // state machine, advanced at decode when leaving idle, otherwise only at the end of the write phase
  // --------------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      isx_pkg::ISX_IDLE: begin
        if (accept) begin
          state_nxt = isx_pkg::ISX_EXEC;
        end
      end
      isx_pkg::ISX_EXEC: begin
        if (inWrite) begin
          state_nxt = flush_r ? isx_pkg::ISX_SKIP_FIRST : isx_pkg::ISX_IDLE;  // RQ6
        end
      end
      isx_pkg::ISX_SKIP_FIRST: begin
        if (inWrite) begin
          // a two-word victim needs its second word replaced too
          state_nxt = twoWord_r ? isx_pkg::ISX_SKIP_SECOND : isx_pkg::ISX_IDLE;  // RQ7
        end
      end
      isx_pkg::ISX_SKIP_SECOND: begin
        if (inWrite) begin
          state_nxt = isx_pkg::ISX_IDLE;  // RQ7
        end
      end
      default: begin
        state_nxt = isx_pkg::ISX_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // next values of the outputs; each lands one clock later in its phase
  // --------------------------------------------------------------------------
  // read strobe rises for the read phase only
  wire rdEn_nxt   = accept;                                              // RQ13
  // write enables cover the write phase only, picked by the destination bit
  wire wrEn_nxt   = executing && inProcess && destBit_r;                 // RQ3
  wire wregEn_nxt = executing && inProcess && !destBit_r;                // RQ4
  // flush is raised through the write phase so the fetch unit sees it before
  // the next cycle's decode; the fetched word is then never executed
  wire flush_nxt  = executing && inProcess && skipTake;                  // RQ5
  wire skipping   = (state_nxt == isx_pkg::ISX_SKIP_FIRST) ||
                    (state_nxt == isx_pkg::ISX_SKIP_SECOND);
  wire busy_nxt   = (state_nxt != isx_pkg::ISX_IDLE);

  // --------------------------------------------------------------------------
  // operand latch at decode
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      destBit_r    <= 1'b0;
      skipOnZero_r <= 1'b0;
      memAddr_r    <= '0;
    end else if (accept) begin
      destBit_r    <= instrWord[isx_pkg::DEST_BIT];
      skipOnZero_r <= isZeroOp;
      memAddr_r    <= decodedAddr;
    end
  end

  // --------------------------------------------------------------------------
  // state, strobes and status
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r      <= isx_pkg::ISX_IDLE;
      memRdEn_r    <= 1'b0;
      memWrEn_r    <= 1'b0;
      wregWrEn_r   <= 1'b0;
      flush_r      <= 1'b0;
      skipActive_r <= 1'b0;
      busy_r       <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      memRdEn_r    <= rdEn_nxt;
      memWrEn_r    <= wrEn_nxt;
      wregWrEn_r   <= wregEn_nxt;
      flush_r      <= flush_nxt;
      skipActive_r <= skipping;                                          // RQ13
      busy_r       <= busy_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // result data, held until the next processed instruction
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      memWrData_r <= '0;
      wregData_r  <= '0;
    end else if (executing && inProcess) begin
      memWrData_r <= incResult;                                          // RQ3
      wregData_r  <= incResult;                                          // RQ4
    end
  end

  // --------------------------------------------------------------------------
  // length of the fetched-ahead word, sampled in the write phase of the executing cycle
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      twoWord_r <= 1'b0;
    end else if (executing && inWrite) begin
      twoWord_r <= nextTwoWord;                                          // RQ7
    end
  end

  // --------------------------------------------------------------------------
  // outputs straight from flip-flops
  // --------------------------------------------------------------------------
  assign memAddr    = memAddr_r;
  assign memRdEn    = memRdEn_r;
  assign memWrEn    = memWrEn_r;
  assign memWrData  = memWrData_r;
  assign wregWrEn   = wregWrEn_r;
  assign wregData   = wregData_r;
  assign flushFetch = flush_r;
  assign skipActive = skipActive_r;
  assign busy       = busy_r;

endmodule

// File: isx_exec_props.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// port checker for the increment-and-skip block
// ---------------------------------------------------------------
module isx_exec_props #(
  parameter int ADDR_W = 12,
  parameter int BANK_W = 4
) (
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic [15:0]       instrWord,
  input wire logic              nextTwoWord,
  input wire logic [BANK_W-1:0] bankSelectReg,
  input wire logic [7:0]        memRdData,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic              memRdEn,
  input wire logic              memWrEn,
  input wire logic [7:0]        memWrData,
  input wire logic              wregWrEn,
  input wire logic [7:0]        wregData,
  input wire logic              flushFetch,
  input wire logic              skipActive,
  input wire logic              busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // either destination strobe marks the write phase
  wire logic wrAny = memWrEn | wregWrEn;
  // one skip cycle is four quiet phases
  sequence s_skip4;
    skipActive[*4];
  endsequence
  property p_rd_wr; memRdEn |-> ##2 wrAny && busy; endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("no write two clocks after read");
  property p_one_dest; !(memWrEn && wregWrEn); endproperty
  a_one_dest: assert property (p_one_dest) else $error("both destinations written");
  property p_result;
    wrAny |-> wregData == $past(memRdData) + 8'h01 && memWrData == wregData;
  endproperty
  a_result: assert property (p_result) else $error("result is not read plus one");
  property p_dest; wrAny |-> memWrEn == $past(instrWord[9], 3); endproperty
  a_dest: assert property (p_dest) else $error("wrong destination");
  // skip-if-zero flushes on zero, the companion flushes on non-zero
  property p_skip_cond;
    wrAny |-> flushFetch == (($past(instrWord[15:10], 3) == 6'h0f) == (wregData == 8'h00));
  endproperty
  a_skip_cond: assert property (p_skip_cond) else $error("skip decision wrong");
  property p_bank;
    memRdEn && $past(instrWord[8]) |->
      memAddr == {$past(bankSelectReg), $past(instrWord[7:0])};
  endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");
  property p_skip_one; flushFetch && !nextTwoWord |=> s_skip4 ##1 !skipActive; endproperty
  a_skip_one: assert property (p_skip_one) else $error("single skip length wrong");
  property p_skip_two;
    flushFetch && nextTwoWord |=> s_skip4 ##1 s_skip4 ##1 !skipActive;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("double skip length wrong");
  property p_quiet; skipActive |-> !memRdEn && !wrAny; endproperty
  a_quiet: assert property (p_quiet) else $error("strobe during skip");
  // without a taken skip the next cycle is a free decode, never a skip
  property p_no_skip; wrAny && !flushFetch |=> !skipActive; endproperty
  a_no_skip: assert property (p_no_skip) else $error("skip without flush");
endmodule

bind isx_exec isx_exec_props #(.ADDR_W(ADDR_W), .BANK_W(BANK_W)) isx_exec_props_i (
  .core_clk, .rst_n, .instrWord, .nextTwoWord, .bankSelectReg, .memRdData, .memAddr,
  .memRdEn, .memWrEn, .memWrData, .wregWrEn, .wregData, .flushFetch, .skipActive, .busy);

// File: isx_tb.sv
`timescale 1ns/100ps
module tb;
  typedef struct {
    logic [15:0] w; logic ext; logic [3:0] bank; logic [11:0] base;
    logic [7:0] rd; logic two; logic [11:0] addr; logic [7:0] res; logic skip;
  } isx_row_s;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] instrWord = 16'h0000;
  logic        instrValid = 1'b0;
  logic        nextTwoWord = 1'b0;
  logic        extEnable = 1'b0;
  logic [3:0]  bankSelectReg = 4'h0;
  logic [11:0] indexBase = 12'h000;
  logic [7:0]  memRdData = 8'h00;
  logic [11:0] memAddr;
  logic        memRdEn, memWrEn, wregWrEn, flushFetch, skipActive, busy;
  logic [7:0]  memWrData, wregData;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  isx_row_s    rows[10];
  isx_exec isx_exec_i (.core_clk(core_clk), .rst_n(rst_n), .instrWord(instrWord),
    .instrValid(instrValid), .nextTwoWord(nextTwoWord), .extEnable(extEnable),
    .bankSelectReg(bankSelectReg), .indexBase(indexBase), .memRdData(memRdData),
    .memAddr(memAddr), .memRdEn(memRdEn), .memWrEn(memWrEn), .memWrData(memWrData),
    .wregWrEn(wregWrEn), .wregData(wregData), .flushFetch(flushFetch),
    .skipActive(skipActive), .busy(busy));
  // ---------------------------------------------------------------
  // clock, watchdog and reporting
  // ---------------------------------------------------------------
  always #2.5 core_clk = ~core_clk;
  // run needs about a hundred cycles, so 1000 means a hang
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checked %0d, errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk1(input string nm, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s exp %b got %b", nm, exp, got);
    end
  endtask
  task automatic chkv(input string nm, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // ---------------------------------------------------------------
  // one instruction from phase 0 to the end of its skip cycles
  // ---------------------------------------------------------------
  task automatic run(input isx_row_s r);
    instrWord = r.w;
    instrValid = 1'b1;
    extEnable = r.ext;
    bankSelectReg = r.bank;
    indexBase = r.base;
    @(negedge core_clk);
    instrValid = 1'b0;
    chk1("rdEn", 1'b1, memRdEn);
    chkv("addr", r.addr, memAddr);
    memRdData = r.rd;
    nextTwoWord = r.two;
    repeat (2) @(negedge core_clk);
    chk1("memWr", r.w[9], memWrEn);
    chk1("wregWr", ~r.w[9], wregWrEn);
    chkv("wreg", {4'h0, r.res}, {4'h0, wregData});
    chkv("wrData", {4'h0, r.res}, {4'h0, memWrData});
    chk1("flush", r.skip, flushFetch);
    if (r.skip) begin
      // a valid word offered at the first skip decode has to be dropped
      instrValid = 1'b1;
      for (int i = 0; i < (r.two ? 8 : 4); i++) begin
        @(negedge core_clk);
        if (i == 1) instrValid = 1'b0;
        chk1("skip", 1'b1, skipActive);
        chk1("rdEnSkip", 1'b0, memRdEn);
        chk1("busySkip", 1'b1, busy);
      end
    end
    // one more clock puts the bench inside the next decode phase, before its decode edge
    @(negedge core_clk);
    chk1("busyEnd", 1'b0, busy);
    chk1("skipEnd", 1'b0, skipActive);
  endtask
  // ---------------------------------------------------------------
  // table of cases, then hand-written awkward ones
  // ---------------------------------------------------------------
  initial begin
    rows = '{
      '{16'h3f34, 1'b0, 4'h2, 12'h000, 8'h10, 1'b0, 12'h234, 8'h11, 1'b0},
      '{16'h3d34, 1'b0, 4'h2, 12'h000, 8'hff, 1'b0, 12'h234, 8'h00, 1'b1},
      '{16'h3e20, 1'b0, 4'h5, 12'h000, 8'hff, 1'b1, 12'h020, 8'h00, 1'b1},
      '{16'h3e80, 1'b0, 4'h5, 12'h000, 8'h7f, 1'b0, 12'hf80, 8'h80, 1'b0},
      '{16'h3e5f, 1'b1, 4'h5, 12'h100, 8'h00, 1'b0, 12'h15f, 8'h01, 1'b0},
      '{16'h3e60, 1'b1, 4'h5, 12'h100, 8'h00, 1'b0, 12'hf60, 8'h01, 1'b0},
      '{16'h4b05, 1'b0, 4'h7, 12'h000, 8'h05, 1'b0, 12'h705, 8'h06, 1'b1},
      '{16'h4a10, 1'b1, 4'h7, 12'hff0, 8'hff, 1'b0, 12'h000, 8'h00, 1'b0},
      '{16'h4905, 1'b0, 4'hf, 12'h000, 8'h41, 1'b1, 12'hf05, 8'h42, 1'b1},
      '{16'h3cff, 1'b1, 4'h3, 12'h000, 8'h00, 1'b0, 12'hfff, 8'h01, 1'b0}};
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    foreach (rows[i]) run(rows[i]);
    // an unrelated opcode must start nothing
    instrWord = 16'h2800;
    instrValid = 1'b1;
    @(negedge core_clk);
    instrValid = 1'b0;
    chk1("otherOp", 1'b0, memRdEn);
    chk1("otherBusy", 1'b0, busy);
    repeat (3) @(negedge core_clk);
    // reset in the process phase clears busy and the address; the read strobe has already fallen by then
    instrWord = 16'h3f34;
    instrValid = 1'b1;
    @(negedge core_clk);
    instrValid = 1'b0;
    @(negedge core_clk);
    rst_n = 1'b0;
    @(negedge core_clk);
    chk1("rstRd", 1'b0, memRdEn);
    chk1("rstBusy", 1'b0, busy);
    chkv("rstAddr", 12'h000, memAddr);
    @(negedge core_clk);
    rst_n = 1'b1;
    run(rows[1]);
    end_sim();
  end
endmodule
